// ===== sca_bank_stage.sv
// Quadrant choice and per-bank late address inversion
`timescale 1ns/100ps
module sca_bank_stage
  import sca_pkg::*;
(
  input  wire logic [PHYS_AW-1:0]        in_addr,
  input  wire logic [NUM_BANKS-1:0][7:0] bank_n_control,
  output logic      [1:0]                quadrant,
  output logic      [7:0]                bank_ctrl,
  output logic      [PHYS_AW-1:0]        out_addr
);
  // Quadrant fixed from the incoming address before the late bank flips
  assign quadrant  = in_addr[19:18];
  assign bank_ctrl = bank_n_control[quadrant];

  // bank bit 4 flips A18
  // Late flips touch only the memory address, never the quadrant
  assign out_addr = {in_addr[19] ^ bank_ctrl[BNK_INV_A19],
                     in_addr[18] ^ bank_ctrl[BNK_INV_A18],
                     in_addr[17:0]};
endmodule : sca_bank_stage

// ===== sca_mapper.sv
// Split code/data address mapper with AXI4-Lite register slave
// ----------------------------------------
// What this block does
// - Invert A16/A19 on data accesses only
// - Data inversion precedes quadrant selection
// - Bank inversion never changes chosen quadrant
// - Bank zero bit 4 flips A18
// - Split control: zeros, force CS2, inversions
// - A19 flip moves by 512K
// - A16 flip moves to adjacent 64K
// - Root and data segments selected separately
// - Separation only in root and data
// - Stack and window never split-inverted; bank flips still apply
// - Root/data boundary from low nibble
// - E000 to FFFF through paged window
// - 8-bit page picks 4K start
// - Short transfers leave page untouched
// - Long transfers update page and counter
// - Long transfer reaches whole 1M
// - Bit 2 data A16, bit 1 root A19
// - Root A19 flip before bank choice
// ----------------------------------------
`timescale 1ns/100ps
module sca_mapper
  import sca_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire sca_pkg::sca_core_req_s  core_req,
  input  wire sca_pkg::sca_long_xfer_s long_xfer,
  output sca_pkg::sca_mem_s          mem_q,
  output logic [LOG_AW-1:0]          pc_q
);
  import sca_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]                 split_space_control_q;
  logic [7:0]                 segment_boundary_q;
  logic [7:0]                 data_segment_base_q;
  logic [7:0]                 stack_segment_base_q;
  logic [7:0]                 ext_code_page_q;
  logic [NUM_BANKS-1:0][7:0]  bank_n_control_q;
  logic                       aw_have_q;
  logic                       w_have_q;
  logic [AXI_AW-1:0]          waddr_q;
  logic [7:0]                 wdata_q;
  logic                       wstrb0_q;
  logic                       wr_fire;
  logic                       wr_hit;
  logic [31:0]                rd_mux;
  logic                       rd_hit;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  sca_zone_e                  zone;
  logic [PHYS_AW-1:0]         seg_addr;
  logic [PHYS_AW-1:0]         inv_addr;
  logic [PHYS_AW-1:0]         bank_addr;
  logic [1:0]                 quadrant;
  logic [7:0]                 bank_ctrl;
  logic                       flip_a16;
  logic                       flip_a19;

  sca_seg_xlate u_seg
  (
    .log_addr           (core_req.addr),
    .segment_boundary   (segment_boundary_q),
    .data_segment_base  (data_segment_base_q),
    .stack_segment_base (stack_segment_base_q),
    .ext_code_page      (ext_code_page_q),
    .zone               (zone),
    .phys_addr          (seg_addr)
  );

  // bit 2 and bit 1 meaning
  always_comb
  begin
    flip_a16 = 1'b0;
    flip_a19 = 1'b0;
    if (core_req.is_data && zone == ZONE_ROOT)
    begin
      flip_a16 = split_space_control_q[SPL_ROOT_A16];
      flip_a19 = split_space_control_q[SPL_ROOT_A19];
    end
    else if (core_req.is_data && zone == ZONE_DATA)
    begin
      flip_a16 = split_space_control_q[SPL_DSEG_A16];
      flip_a19 = split_space_control_q[SPL_DSEG_A19];
    end
  end

  // A16 flip moves one 64K page
  // root A19 flip ahead of banks
  assign inv_addr = {seg_addr[19] ^ flip_a19, seg_addr[18:17],
                     seg_addr[16] ^ flip_a16, seg_addr[15:0]};

  sca_bank_stage u_bank
  (
    .in_addr        (inv_addr),
    .bank_n_control (bank_n_control_q),
    .quadrant       (quadrant),
    .bank_ctrl      (bank_ctrl),
    .out_addr       (bank_addr)
  );

  // Memory pins registered so chip selects never glitch
  // force second select
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_q <= '{addr: '0, first_chip_select_n: 1'b1, second_chip_select_n: 1'b1,
                 first_read_strobe_n: 1'b1, first_write_strobe_n: 1'b1};
    end
    else
    begin
      mem_q.addr                 <= bank_addr;
      mem_q.first_chip_select_n  <= !(core_req.valid && !bank_ctrl[BNK_SEL_CS2]);
      mem_q.second_chip_select_n <= !((core_req.valid && bank_ctrl[BNK_SEL_CS2])
                                      || split_space_control_q[SPL_FORCE_CS2]);
      mem_q.first_read_strobe_n  <= !(core_req.valid && !core_req.write);
      mem_q.first_write_strobe_n <= !(core_req.valid && core_req.write
                                      && bank_ctrl[BNK_WR_EN]);
    end
  end

  // ----------------------------------------
  // Page and program counter
  // ----------------------------------------
  // only long transfers or software move the page
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_code_page_q <= REG_RESET;
      pc_q            <= '0;
    end
    else if (long_xfer.valid)
    begin
      ext_code_page_q <= long_xfer.page;
      pc_q            <= long_xfer.pc;
    end
    else if (wr_fire && wstrb0_q && waddr_q == OFS_XPAGE)
    begin
      ext_code_page_q <= wdata_q;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_hit  = (waddr_q <= OFS_BANK3) && (waddr_q[1:0] == 2'b00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      waddr_q       <= '0;
      wdata_q       <= REG_RESET;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q     <= 1'b1;
        waddr_q       <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb0_q     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      // Ready returns only after the answer, one write at a time
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      split_space_control_q <= REG_RESET;
      segment_boundary_q    <= REG_RESET;
      data_segment_base_q   <= REG_RESET;
      stack_segment_base_q  <= REG_RESET;
      bank_n_control_q      <= '0;
    end
    else if (wr_fire && wstrb0_q)
    begin
      unique case (waddr_q)
        // top three bits held at zero
        OFS_SPLIT: split_space_control_q <= wdata_q & SPL_RW_MASK;
        OFS_SEGB:  segment_boundary_q    <= wdata_q;
        OFS_DSEG:  data_segment_base_q   <= wdata_q;
        OFS_SSEG:  stack_segment_base_q  <= wdata_q;
        default:
        begin
          if (waddr_q >= OFS_BANK0 && waddr_q <= OFS_BANK3)
          begin
            bank_n_control_q[2'(waddr_q[7:2] - OFS_BANK0[7:2])] <= wdata_q;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
      OFS_SPLIT:  rd_mux = {24'h000000, split_space_control_q};
      OFS_SEGB:   rd_mux = {24'h000000, segment_boundary_q};
      OFS_DSEG:   rd_mux = {24'h000000, data_segment_base_q};
      OFS_SSEG:   rd_mux = {24'h000000, stack_segment_base_q};
      OFS_XPAGE:  rd_mux = {24'h000000, ext_code_page_q};
      8'h14:      rd_mux = {24'h000000, bank_n_control_q[0]};
      8'h18:      rd_mux = {24'h000000, bank_n_control_q[1]};
      8'h1c:      rd_mux = {24'h000000, bank_n_control_q[2]};
      OFS_BANK3:  rd_mux = {24'h000000, bank_n_control_q[3]};
      OFS_STATUS: rd_mux = {12'h000, mem_q.addr};
      OFS_PC:     rd_mux = {16'h0000, pc_q};
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_inst_no_flip:
    assert property (!core_req.is_data |-> inv_addr == seg_addr)
      else $error("instruction fetch address was inverted");
  a_quad_after_flip:
    assert property (quadrant == inv_addr[19:18] && bank_addr[17:0] == inv_addr[17:0])
      else $error("quadrant not taken from inverted address");
  a_root_a19_quad:
    assert property (core_req.is_data && zone == ZONE_ROOT
                     && split_space_control_q[SPL_ROOT_A19]
                     |-> quadrant == {~seg_addr[19], seg_addr[18]})
      else $error("root A19 flip missed quadrant choice");
  a_bank_zero_a18:
    assert property (quadrant == 2'b00 && bank_n_control_q[0][BNK_INV_A18]
                     |-> bank_addr[18] != inv_addr[18])
      else $error("bank zero A18 flip missing");
  a_force_cs2:
    assert property (split_space_control_q[SPL_FORCE_CS2] |=> !mem_q.second_chip_select_n
                     && split_space_control_q[7:5] == 3'b000)
      else $error("second chip select not forced or top bits set");
  a_dseg_a19_flip:
    assert property (core_req.is_data && zone == ZONE_DATA
                     && split_space_control_q[SPL_DSEG_A19]
                     && !split_space_control_q[SPL_DSEG_A16]
                     |-> inv_addr == (seg_addr ^ 20'h80000))
      else $error("data segment A19 flip wrong");
  a_root_a16_flip:
    assert property (core_req.is_data && zone == ZONE_ROOT
                     && split_space_control_q[SPL_ROOT_A16]
                     && !split_space_control_q[SPL_ROOT_A19]
                     |-> inv_addr == (seg_addr ^ 20'h10000))
      else $error("root A16 flip wrong");
  a_combined_zones:
    assert property (zone == ZONE_STACK || zone == ZONE_WINDOW |-> inv_addr == seg_addr)
      else $error("stack or window address was inverted");
  a_root_boundary:
    assert property (core_req.addr[15:12] < segment_boundary_q[3:0]
                     && core_req.addr[15:12] < segment_boundary_q[7:4]
                     && core_req.addr[15:12] < WINDOW_PAGE
                     |-> zone == ZONE_ROOT && seg_addr == {4'h0, core_req.addr})
      else $error("root segment boundary wrong");
  a_window_map:
    assert property (core_req.addr[15:12] >= WINDOW_PAGE |-> zone == ZONE_WINDOW
                     && seg_addr == 20'({4'h0, core_req.addr} + {ext_code_page_q, 12'h000}))
      else $error("window address wrong");
  a_long_xfer_load:
    assert property (long_xfer.valid |=> ext_code_page_q == $past(long_xfer.page)
                     && pc_q == $past(long_xfer.pc))
      else $error("long transfer did not load page and counter");
  a_page_hold:
    assert property (!long_xfer.valid && !wr_fire |=> $stable(ext_code_page_q))
      else $error("page moved without long transfer or write");
  a_write_answer:
    assert property (wr_fire |=> s_axi_bvalid && !aw_have_q && !w_have_q)
      else $error("write answer missing");
endmodule : sca_mapper

// ===== sca_mapper_test.sv
// Self-checking bench for the split code/data address mapper
`timescale 1ns/100ps
module sca_mapper_test;
  import sca_pkg::*;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [AXI_AW-1:0]   awaddr = 8'h00, araddr = 8'h00;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0;
  logic [31:0]         wdata = 32'h0, rdata;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [1:0]          bresp, rresp, resp;
  sca_core_req_s       core_req = '0;
  sca_long_xfer_s      long_xfer = '0;
  sca_mem_s            mem_q;
  logic [LOG_AW-1:0]   pc_q;
  logic [7:0]          reads_first, reads_second;
  logic [31:0]         v;
  int                  fail_count = 0;
  int                  checks_done = 0;

  always #12.5 aclk = ~aclk;

  sca_mapper sca_mapper_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .core_req(core_req), .long_xfer(long_xfer),
    .mem_q(mem_q), .pc_q(pc_q));

  sca_mem_model sca_mem_model_inst (.aclk(aclk), .aresetn(aresetn), .mem(mem_q),
    .reads_first(reads_first), .reads_second(reads_second));

  // ----------------------------------------
  // Compare tasks and verdict
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t word got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_addr(input logic [19:0] g, input logic [19:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t phys addr got %h exp %h", $time, g, e);
    end
  endtask : chk_addr

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // AXI4-Lite master, waits bounded by a count
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50)
    begin
      fail_count++;
      $display("[FAIL] %0t write answer timed out", $time);
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50)
    begin
      fail_count++;
      $display("[FAIL] %0t read answer timed out", $time);
    end
  endtask : rd

  // One core access; mem_q is looked at one edge later
  task automatic run_case(input logic [7:0] s, input logic d, input logic [15:0] a,
                          input logic [19:0] e, input logic c2);
    wr(OFS_SPLIT, s, resp);
    @(posedge aclk);
    core_req <= '{valid: 1'b1, is_data: d, write: 1'b0, addr: a};
    @(posedge aclk);
    core_req.valid <= 1'b0;
    #1;
    chk_addr(mem_q.addr, e);
    chk_word({31'h0, mem_q.second_chip_select_n}, {31'h0, c2});
    chk_word({31'h0, mem_q.first_chip_select_n}, {31'h0, ~c2});
    chk_word({31'h0, mem_q.first_read_strobe_n}, 32'h0);
    chk_word({31'h0, mem_q.first_write_strobe_n}, 32'h1);
  endtask : run_case

  initial
  begin
    #(25ns * 6000);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      rd(8'(i * 4), v, resp);
      chk_word(v, 32'h0);
      chk_word({30'h0, resp}, {30'h0, RESP_OKAY});
    end
    rd(8'h2c, v, resp);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_STATUS, 8'h5a, resp);
    chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_SPLIT, 8'hff, resp);
    rd(OFS_SPLIT, v, resp);
    chk_word(v, 32'h1f);
    wr(OFS_SEGB, 8'hd4, resp);
    wr(OFS_DSEG, 8'h02, resp);
    wr(OFS_SSEG, 8'h20, resp);
    wr(OFS_XPAGE, 8'hff, resp);
    run_case(8'h09, 1'b1, 16'h1234, 20'h11234, 1'b1);
    run_case(8'h09, 1'b0, 16'h1234, 20'h01234, 1'b1);
    run_case(8'h09, 1'b1, 16'h5000, 20'h87000, 1'b1);
    run_case(8'h09, 1'b0, 16'h5000, 20'h07000, 1'b1);
    run_case(8'h09, 1'b1, 16'h3fff, 20'h13fff, 1'b1);
    run_case(8'h09, 1'b1, 16'h4000, 20'h86000, 1'b1);
    run_case(8'h0f, 1'b1, 16'hdfff, 20'h2dfff, 1'b1);
    run_case(8'h0f, 1'b1, 16'he123, 20'h0d123, 1'b1);
    run_case(8'h06, 1'b1, 16'h1234, 20'h81234, 1'b1);
    run_case(8'h06, 1'b1, 16'h5000, 20'h17000, 1'b1);
    wr(OFS_BANK0, 8'h10, resp);
    wr(OFS_BANK0 + 8'h08, 8'h01, resp);
    wr(OFS_BANK3, 8'h21, resp);
    wr(OFS_SSEG, 8'hc0, resp);
    run_case(8'h02, 1'b0, 16'h1234, 20'h41234, 1'b1);
    run_case(8'h02, 1'b1, 16'h1234, 20'h81234, 1'b0);
    run_case(8'h02, 1'b1, 16'hd100, 20'h4d100, 1'b0);
    @(posedge aclk);
    #1;
    chk_word({24'h0, reads_second}, 32'h2);
    chk_word({24'h0, reads_first}, 32'hb);
    // Long transfer moves page and counter together
    @(posedge aclk);
    long_xfer <= '{valid: 1'b1, page: 8'h80, pc: 16'he000};
    @(posedge aclk);
    long_xfer.valid <= 1'b0;
    @(posedge aclk);
    #1;
    chk_word({16'h0, pc_q}, 32'he000);
    rd(OFS_XPAGE, v, resp);
    chk_word(v, 32'h80);
    rd(OFS_PC, v, resp);
    chk_word(v, 32'he000);
    run_case(8'h00, 1'b0, 16'he010, 20'h8e010, 1'b0);
    run_case(8'h00, 1'b0, 16'h0100, 20'h40100, 1'b1);
    rd(OFS_XPAGE, v, resp);
    chk_word(v, 32'h80);
    // Write through bank zero with write strobe allowed
    wr(OFS_BANK0, 8'h12, resp);
    @(posedge aclk);
    core_req <= '{valid: 1'b1, is_data: 1'b1, write: 1'b1, addr: 16'h0100};
    @(posedge aclk);
    core_req.valid <= 1'b0;
    #1;
    chk_addr(mem_q.addr, 20'h40100);
    chk_word({30'h0, mem_q.first_write_strobe_n, mem_q.first_read_strobe_n}, 32'h1);
    // Forced second select holds even while idle
    wr(OFS_SPLIT, 8'h10, resp);
    repeat (2) @(posedge aclk);
    #1;
    chk_word({31'h0, mem_q.second_chip_select_n}, 32'h0);
    tally_and_finish();
  end
endmodule : sca_mapper_test

// ===== sca_mem_model.sv
// Behavioural flash and RAM pair watching the mapped memory strobes
`timescale 1ns/100ps
module sca_mem_model
  import sca_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire sca_pkg::sca_mem_s   mem,
  output logic [7:0]               reads_first,
  output logic [7:0]               reads_second
);
  import sca_pkg::*;
  // ----------------------------------------
  // Read counting per chip
  // ----------------------------------------
  // Counts strobes only, no data bus exists on the mapper side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reads_first  <= 8'h00;
      reads_second <= 8'h00;
    end
    else if (!mem.first_read_strobe_n)
    begin
      if (!mem.first_chip_select_n)
        reads_first <= reads_first + 8'h01;
      if (!mem.second_chip_select_n)
        reads_second <= reads_second + 8'h01;
    end
  end
endmodule : sca_mem_model

// ===== sca_pkg.sv
// Shared constants and types for the split code/data address mapper
package sca_pkg;
  // ----------------------------------------
  // Bus and address widths
  // ----------------------------------------
  localparam int unsigned AXI_AW    = 8;
  localparam int unsigned LOG_AW    = 16;
  localparam int unsigned PHYS_AW   = 20;
  localparam int unsigned NUM_BANKS = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_SPLIT    = 8'h00;
  localparam logic [7:0] OFS_SEGB     = 8'h04;
  localparam logic [7:0] OFS_DSEG     = 8'h08;
  localparam logic [7:0] OFS_SSEG     = 8'h0c;
  localparam logic [7:0] OFS_XPAGE    = 8'h10;
  localparam logic [7:0] OFS_BANK0    = 8'h14;
  localparam logic [7:0] OFS_BANK3    = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;
  localparam logic [7:0] OFS_PC       = 8'h28;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int unsigned SPL_ROOT_A16  = 0;
  localparam int unsigned SPL_ROOT_A19  = 1;
  localparam int unsigned SPL_DSEG_A16  = 2;
  localparam int unsigned SPL_DSEG_A19  = 3;
  localparam int unsigned SPL_FORCE_CS2 = 4;
  localparam logic [7:0]  SPL_RW_MASK   = 8'h1f;
  localparam int unsigned BNK_SEL_CS2   = 0;
  localparam int unsigned BNK_WR_EN     = 1;
  localparam int unsigned BNK_INV_A18   = 4;
  localparam int unsigned BNK_INV_A19   = 5;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam logic [3:0]  WINDOW_PAGE   = 4'he;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ZONE_ROOT, ZONE_DATA, ZONE_STACK, ZONE_WINDOW} sca_zone_e;

  typedef struct packed {
    logic               valid;
    logic               is_data;
    logic               write;
    logic [LOG_AW-1:0]  addr;
  } sca_core_req_s;

  typedef struct packed {
    logic               valid;
    logic [7:0]         page;
    logic [LOG_AW-1:0]  pc;
  } sca_long_xfer_s;

  typedef struct packed {
    logic [PHYS_AW-1:0] addr;
    logic               first_chip_select_n;
    logic               second_chip_select_n;
    logic               first_read_strobe_n;
    logic               first_write_strobe_n;
  } sca_mem_s;
endpackage : sca_pkg

// ===== sca_seg_xlate.sv
// Logical to physical segment translation ahead of data-space inversion
`timescale 1ns/100ps
module sca_seg_xlate
  import sca_pkg::*;
(
  input  wire logic [LOG_AW-1:0]  log_addr,
  input  wire logic [7:0]         segment_boundary,
  input  wire logic [7:0]         data_segment_base,
  input  wire logic [7:0]         stack_segment_base,
  input  wire logic [7:0]         ext_code_page,
  output sca_zone_e               zone,
  output logic      [PHYS_AW-1:0] phys_addr
);
  logic [PHYS_AW-1:0] wide_addr;
  logic [7:0]         base;

  assign wide_addr = {4'h0, log_addr};

  always_comb
  begin
    // Window first, so the top 8K never falls to a fixed segment
    if (log_addr[15:12] >= WINDOW_PAGE)
    begin
      zone = ZONE_WINDOW;
      base = ext_code_page;
    end
    else if (log_addr[15:12] >= segment_boundary[7:4])
    begin
      zone = ZONE_STACK;
      base = stack_segment_base;
    end
    else if (log_addr[15:12] >= segment_boundary[3:0])
    begin
      zone = ZONE_DATA;
      base = data_segment_base;
    end
    else
    begin
      zone = ZONE_ROOT;
      base = REG_RESET;
    end
  end

  // page times 4096 plus logical
  // Carry above bit 19 drops, so the window wraps in 1M
  assign phys_addr = wide_addr + {base, 12'h000};
endmodule : sca_seg_xlate
